// ===== dsa_pkg.sv
// Constants, field layout and types shared by the dual converter serial port.
// What this block does
// - Serial output stays undriven during write transfers.
// - Serial input ignored during read transfers.
// - All serial words move most significant bit first.
// - Status register holds main and auxiliary flags.
// - Active-low ready pin shows any unread result.
// - Port works with select tied low.
// - Main rate programmable, 5.35 Hz to 105.03 Hz.
// - Main results up to 24 bits, chopped.
// - Main range selectable among eight settings.
// - Main input buffered while buffer-disable is zero.
// - Auxiliary span bit picks full or half reference.
// - Main pairing from two selects and configuration bit.
// - Auxiliary input from three select bits.
// - Auxiliary results are sixteen bits wide.
// - Switchable burnout currents on the selected channel.
// - All timing derives from the crystal master clock.
// - Every access starts with a communications write.
// - Requested transfer follows the eighth clock immediately.
package dsa_pkg;

    // ==========================================================
    // Serial sequencer states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ST_COMM  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10
    } dsa_seq_type;

    // ==========================================================
    // Register addresses carried in the communications byte.
    localparam logic [3:0] ADDR_STATUS    = 4'h0;
    localparam logic [3:0] ADDR_MODE      = 4'h1;
    localparam logic [3:0] ADDR_MAIN_CTRL = 4'h2;
    localparam logic [3:0] ADDR_AUX_CTRL  = 4'h3;
    localparam logic [3:0] ADDR_FILTER    = 4'h4;
    localparam logic [3:0] ADDR_MAIN_DATA = 4'h5;
    localparam logic [3:0] ADDR_AUX_DATA  = 4'h6;

    // ==========================================================
    // Field positions.
    localparam int COMM_RW_BIT      = 6;
    localparam int COMM_ADDR_MSB    = 3;
    localparam int STAT_MAIN_BIT    = 0;
    localparam int STAT_AUX_BIT     = 1;
    localparam int MODE_PAIRING_BIT = 0;
    localparam int MODE_BURNOUT_BIT = 1;
    localparam int MODE_CHOP_BIT    = 2;
    localparam int CTRL_RANGE_LSB   = 0;
    localparam int CTRL_RANGE_MSB   = 2;
    localparam int CTRL_BUF_N_BIT   = 3;
    localparam int CTRL_SEL_LO_BIT  = 4;
    localparam int CTRL_SEL_HI_BIT  = 5;
    localparam int CTRL_WIDE_BIT    = 6;
    localparam int AUX_SEL_LSB      = 0;
    localparam int AUX_SEL_MSB      = 2;
    localparam int AUX_SPAN_BIT     = 3;

    // ==========================================================
    // Widths, transfer lengths and reset values.
    localparam int         MAIN_W    = 24;
    localparam int         AUX_W     = 16;
    localparam int         REG_W     = 8;
    localparam logic [4:0] LEN_BYTE  = 5'h08;
    localparam logic [4:0] LEN_HALF  = 5'h10;
    localparam logic [4:0] LEN_FULL  = 5'h18;
    localparam logic [7:0] MODE_RST  = 8'h04;
    localparam logic [7:0] MAIN_RST  = 8'h47;
    localparam logic [7:0] AUX_RST   = 8'h00;
    localparam logic [7:0] FILT_RST  = 8'h45;

endpackage

// ===== dsa_stream_if.sv
// Valid/ready carrier between the port core and its result buffer.
`timescale 1ns/1ps
interface dsa_stream_if #(parameter int WIDTH = 24);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    modport buffer (
        input  in_valid,
        input  in_data,
        input  out_ready,
        output in_ready,
        output out_valid,
        output out_data
    );

    modport user (
        output in_valid,
        output in_data,
        output out_ready,
        input  in_ready,
        input  out_valid,
        input  out_data
    );
endinterface

// ===== dsa_result_buffer.sv
// Small FIFO that holds main-channel results while the data register is unread.
`timescale 1ns/1ps
module dsa_result_buffer
    import dsa_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input  wire logic   clock_i,
    input  wire logic   rst_n_i,
    dsa_stream_if.buffer bus
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST  = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULLC = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        room;
        logic                        empty;
    } dsa_buf_state_type;

    dsa_buf_state_type r_reg;
    dsa_buf_state_type r_next;
    logic              push;
    logic              pop;

    assign bus.in_ready  = r_reg.room;
    assign bus.out_valid = ~r_reg.empty;
    assign bus.out_data  = r_reg.mem[r_reg.rd_ptr];
    assign push          = bus.in_valid & r_reg.room;
    assign pop           = bus.out_ready & ~r_reg.empty;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.mem[r_reg.wr_ptr] = bus.in_data;
            r_next.wr_ptr = (r_reg.wr_ptr == LAST) ? '0 : r_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            r_next.rd_ptr = (r_reg.rd_ptr == LAST) ? '0 : r_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            r_next.count = r_reg.count + 1'b1;
        end else if (pop && !push) begin
            r_next.count = r_reg.count - 1'b1;
        end
        r_next.room  = (r_next.count != FULLC);
        r_next.empty = (r_next.count == '0);
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg       <= '0;
            r_reg.empty <= 1'b1;
            r_reg.room  <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// ===== dsa_serial_port.sv
// Device-side serial port, register file and result flags of the dual converter.
`timescale 1ns/1ps
module dsa_serial_port
    import dsa_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    input  wire logic              din_i,
    output logic                   dout_o,
    output logic                   dout_oe_o,
    output logic                   ready_n_o,
    input  wire logic              main_valid_i,
    input  wire logic [MAIN_W-1:0] main_data_i,
    output logic                   main_ready_o,
    input  wire logic              aux_valid_i,
    input  wire logic [AUX_W-1:0]  aux_data_i,
    output logic                   aux_ready_o,
    output logic [2:0]             main_range_o,
    output logic                   main_buf_n_o,
    output logic                   main_input_sel_hi_o,
    output logic                   main_input_sel_lo_o,
    output logic                   input_pairing_cfg_o,
    output logic                   chop_en_o,
    output logic                   burnout_en_o,
    output logic                   main_wide_o,
    output logic                   aux_span_select_o,
    output logic [2:0]             aux_input_sel_o,
    output logic [REG_W-1:0]       filter_code_o,
    output logic                   main_result_flag_o,
    output logic                   aux_result_flag_o
);

    // ==========================================================
    // State record.
    typedef struct packed {
        logic [2:0]        sclk_sync;
        logic [2:0]        cs_sync;
        logic [2:0]        din_sync;
        logic              sclk_f;
        logic              cs_f;
        logic              din_f;
        dsa_seq_type       seq;
        logic [4:0]        bit_cnt;
        logic [4:0]        len;
        logic [3:0]        addr;
        logic [MAIN_W-1:0] shift;
        logic [REG_W-1:0]  mode;
        logic [REG_W-1:0]  main_ctrl;
        logic [REG_W-1:0]  aux_ctrl;
        logic [REG_W-1:0]  filter;
        logic [MAIN_W-1:0] main_data;
        logic [AUX_W-1:0]  aux_data;
        logic              main_flag;
        logic              aux_flag;
        logic              dout;
        logic              dout_oe;
        logic              ready_n;
        logic              aux_ready;
    } dsa_port_state_type;

    localparam dsa_port_state_type RESET_STATE = '{
        sclk_sync: 3'h7,
        cs_sync: 3'h7,
        din_sync: 3'h0,
        sclk_f: 1'b1,
        cs_f: 1'b1,
        din_f: 1'b0,
        seq: ST_COMM,
        bit_cnt: 5'h00,
        len: 5'h00,
        addr: 4'h0,
        shift: '0,
        mode: MODE_RST,
        main_ctrl: MAIN_RST,
        aux_ctrl: AUX_RST,
        filter: FILT_RST,
        main_data: '0,
        aux_data: '0,
        main_flag: 1'b0,
        aux_flag: 1'b0,
        dout: 1'b0,
        dout_oe: 1'b0,
        ready_n: 1'b1,
        aux_ready: 1'b1
    };

    dsa_port_state_type r_reg;
    dsa_port_state_type r_next;
    logic [1:0]         rst_sync_reg;
    logic               rst_n;
    logic               main_take;

    dsa_stream_if #(.WIDTH(MAIN_W)) main_bus ();

    // ==========================================================
    // Reset release.
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ==========================================================
    // Main results queue here so a host that is slow to read loses no word.
    dsa_result_buffer #(
        .WIDTH (MAIN_W),
        .DEPTH (BUF_DEPTH)
    ) u_main_buffer (
        .clock_i (clock_i),
        .rst_n_i (rst_n),
        .bus     (main_bus.buffer)
    );

    assign main_bus.in_valid  = main_valid_i;
    assign main_bus.in_data   = main_data_i;
    // A new result waits until the previous one has been read out.
    assign main_take          = main_bus.out_valid & ~r_reg.main_flag
                              & ~(r_reg.seq == ST_READ && r_reg.addr == ADDR_MAIN_DATA);
    assign main_bus.out_ready = main_take;

    // ==========================================================
    // Decoders.
    function automatic logic [4:0] xfer_len(
        input logic [3:0] a,
        input logic       wide
    );
        logic [4:0] n;
        n = LEN_BYTE;

        if (a == ADDR_MAIN_DATA) begin
            n = wide ? LEN_FULL : LEN_HALF;
        end else if (a == ADDR_AUX_DATA) begin
            n = LEN_HALF;
        end

        return n;
    endfunction

    function automatic logic writable(
        input logic [3:0] a
    );
        return (a == ADDR_MODE)
            || (a == ADDR_MAIN_CTRL)
            || (a == ADDR_AUX_CTRL)
            || (a == ADDR_FILTER);
    endfunction

    // Read words are left aligned so the shifter always sends its top bit first.
    function automatic logic [MAIN_W-1:0] read_word(
        input dsa_port_state_type s,
        input logic [3:0]         a
    );
        logic [MAIN_W-1:0] w;
        logic [REG_W-1:0]  b;
        b = '0;
        w = '0;

        case (a)
            ADDR_STATUS: begin
                b[STAT_MAIN_BIT] = s.main_flag;
                b[STAT_AUX_BIT]  = s.aux_flag;
            end
            ADDR_MODE:      b = s.mode;
            ADDR_MAIN_CTRL: b = s.main_ctrl;
            ADDR_AUX_CTRL:  b = s.aux_ctrl;
            ADDR_FILTER:    b = s.filter;
            default:        b = '0;
        endcase

        if (a == ADDR_MAIN_DATA) begin
            w = s.main_data;
        end else if (a == ADDR_AUX_DATA) begin
            w = {s.aux_data, {(MAIN_W - AUX_W){1'b0}}};
        end else begin
            w = {b, {(MAIN_W - REG_W){1'b0}}};
        end

        return w;
    endfunction

    // ==========================================================
    // Next-state logic.
    always_comb begin
        logic              sclk_new;
        logic              cs_new;
        logic              din_new;
        logic              rise;
        logic              fall;
        logic [4:0]        cnt;
        logic [MAIN_W-1:0] sh;
        logic [3:0]        a;
        sclk_new = r_reg.sclk_f;
        cs_new   = r_reg.cs_f;
        din_new  = r_reg.din_f;
        rise     = 1'b0;
        fall     = 1'b0;
        cnt      = r_reg.bit_cnt + 5'h01;
        sh       = {r_reg.shift[MAIN_W-2:0], r_reg.din_f};
        a        = r_reg.addr;
        r_next   = r_reg;

        // Pins pass three stages; a level counts once the last two agree.
        r_next.sclk_sync = {r_reg.sclk_sync[1:0], sclk_i};
        r_next.cs_sync   = {r_reg.cs_sync[1:0], cs_n_i};
        r_next.din_sync  = {r_reg.din_sync[1:0], din_i};
        if (r_reg.sclk_sync[1] == r_reg.sclk_sync[2]) begin
            sclk_new = r_reg.sclk_sync[2];
        end

        if (r_reg.cs_sync[1] == r_reg.cs_sync[2]) begin
            cs_new = r_reg.cs_sync[2];
        end

        if (r_reg.din_sync[1] == r_reg.din_sync[2]) begin
            din_new = r_reg.din_sync[2];
        end
        r_next.sclk_f = sclk_new;
        r_next.cs_f   = cs_new;
        r_next.din_f  = din_new;
        rise = sclk_new & ~r_reg.sclk_f;
        fall = ~sclk_new & r_reg.sclk_f;
        sh   = {r_reg.shift[MAIN_W-2:0], din_new};

        // A deselected port drops any partial word and waits for a command.
        if (cs_new) begin
            r_next.seq     = ST_COMM;
            r_next.bit_cnt = 5'h00;
        end else if (rise) begin
            case (r_reg.seq)
                ST_COMM: begin
                    r_next.shift   = sh;
                    r_next.bit_cnt = cnt;
                    if (cnt == LEN_BYTE) begin
                        a              = sh[COMM_ADDR_MSB:0];
                        r_next.addr    = a;
                        r_next.bit_cnt = 5'h00;
                        // The requested transfer starts on the very next clock.
                        if (sh[COMM_RW_BIT]) begin
                            r_next.seq   = ST_READ;
                            r_next.len   = xfer_len(a, r_reg.main_ctrl[CTRL_WIDE_BIT]);
                            r_next.shift = read_word(r_reg, a);
                        end else if (writable(a)) begin
                            r_next.seq = ST_WRITE;
                            r_next.len = LEN_BYTE;
                        end
                    end
                end

                ST_WRITE: begin
                    r_next.shift   = sh;
                    r_next.bit_cnt = cnt;
                    if (cnt == r_reg.len) begin
                        r_next.seq     = ST_COMM;
                        r_next.bit_cnt = 5'h00;
                        case (a)
                            ADDR_MODE:      r_next.mode      = sh[REG_W-1:0];
                            ADDR_MAIN_CTRL: r_next.main_ctrl = sh[REG_W-1:0];
                            ADDR_AUX_CTRL:  r_next.aux_ctrl  = sh[REG_W-1:0];
                            ADDR_FILTER:    r_next.filter    = sh[REG_W-1:0];
                            default:        r_next.mode      = r_reg.mode;
                        endcase
                    end
                end

                ST_READ: begin
                    // The data line is not sampled while the device talks.
                    r_next.bit_cnt = cnt;
                    if (cnt == r_reg.len) begin
                        r_next.seq     = ST_COMM;
                        r_next.bit_cnt = 5'h00;
                        if (a == ADDR_MAIN_DATA) begin
                            r_next.main_flag = 1'b0;
                        end
                        if (a == ADDR_AUX_DATA) begin
                            r_next.aux_flag = 1'b0;
                        end
                    end
                end

                default: begin
                    r_next.seq     = ST_COMM;
                    r_next.bit_cnt = 5'h00;
                end
            endcase
        end else if (fall && r_reg.seq == ST_READ) begin
            r_next.dout  = r_reg.shift[MAIN_W-1];
            r_next.shift = {r_reg.shift[MAIN_W-2:0], 1'b0};
        end

        // Result loads come after the read clears, so a new result wins.
        if (main_take) begin
            r_next.main_data = main_bus.out_data;
            r_next.main_flag = 1'b1;
        end
        if (aux_valid_i && r_reg.aux_ready) begin
            r_next.aux_data = aux_data_i;
            r_next.aux_flag = 1'b1;
        end

        // The output driver is only on while a read is in progress.
        r_next.dout_oe   = ~cs_new & (r_next.seq == ST_READ);
        r_next.ready_n   = ~(r_next.main_flag | r_next.aux_flag);
        r_next.aux_ready = ~(r_next.seq == ST_READ && r_next.addr == ADDR_AUX_DATA);
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= RESET_STATE;
        end else begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs.
    assign dout_o              = r_reg.dout;
    assign dout_oe_o           = r_reg.dout_oe;
    assign ready_n_o           = r_reg.ready_n;
    assign main_ready_o        = main_bus.in_ready;
    assign aux_ready_o         = r_reg.aux_ready;
    assign main_range_o        = r_reg.main_ctrl[CTRL_RANGE_MSB:CTRL_RANGE_LSB];
    assign main_buf_n_o        = r_reg.main_ctrl[CTRL_BUF_N_BIT];
    assign main_input_sel_hi_o = r_reg.main_ctrl[CTRL_SEL_HI_BIT];
    assign main_input_sel_lo_o = r_reg.main_ctrl[CTRL_SEL_LO_BIT];
    assign input_pairing_cfg_o = r_reg.mode[MODE_PAIRING_BIT];
    assign chop_en_o           = r_reg.mode[MODE_CHOP_BIT];
    assign burnout_en_o        = r_reg.mode[MODE_BURNOUT_BIT];
    assign main_wide_o         = r_reg.main_ctrl[CTRL_WIDE_BIT];
    assign aux_span_select_o   = r_reg.aux_ctrl[AUX_SPAN_BIT];
    assign aux_input_sel_o     = r_reg.aux_ctrl[AUX_SEL_MSB:AUX_SEL_LSB];
    // The filter code divides the crystal-derived modulator clock downstream.
    assign filter_code_o       = r_reg.filter;
    assign main_result_flag_o  = r_reg.main_flag;
    assign aux_result_flag_o   = r_reg.aux_flag;

endmodule

// ===== dsa_serial_chk.sv
// Concurrent checks on the pins and result flags of the serial port.
`timescale 1ns/1ps
module dsa_serial_chk
    import dsa_pkg::*;
(
    input logic             clock_i,
    input logic             rstn_i,
    input logic             sclk_i,
    input logic             cs_n_i,
    input logic             dout_o,
    input logic             dout_oe_o,
    input logic             ready_n_o,
    input logic             main_valid_i,
    input logic             main_ready_o,
    input logic             aux_valid_i,
    input logic             aux_ready_o,
    input logic [2:0]       main_range_o,
    input logic [2:0]       aux_input_sel_o,
    input logic [REG_W-1:0] filter_code_o,
    input logic             main_result_flag_o,
    input logic             aux_result_flag_o
);
    // ==========
    // Sequences.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence s_idle;
        cs_n_i [*8];
    endsequence
    sequence s_drive_high;
        (sclk_i && dout_oe_o) [*8];
    endsequence
    sequence s_no_result;
        (!main_result_flag_o && !aux_result_flag_o) [*2];
    endsequence

    // ==========
    // Properties.
    AST_OE_IDLE: assert property (s_idle |-> !dout_oe_o)
        else $error("output enabled while deselected");
    AST_OE_SEL: assert property ($rose(dout_oe_o) |-> !cs_n_i)
        else $error("output enabled outside a transfer");
    AST_DOUT_HOLD: assert property (s_drive_high |-> $stable(dout_o))
        else $error("read data moved while serial clock high");
    AST_RDY_HIGH: assert property (s_no_result |-> ready_n_o)
        else $error("ready pin low with no unread result");
    AST_RDY_LOW: assert property ((main_result_flag_o || aux_result_flag_o) [*2] |-> !ready_n_o)
        else $error("ready pin high with an unread result");
    AST_MAIN_CLR: assert property ($fell(main_result_flag_o) |-> !cs_n_i)
        else $error("main flag cleared without a read");
    AST_AUX_SET: assert property (aux_valid_i && aux_ready_o && cs_n_i |=> aux_result_flag_o)
        else $error("aux flag not set after accepted result");
    AST_MAIN_SET: assert property (main_valid_i && main_ready_o && cs_n_i |-> ##[1:4] main_result_flag_o)
        else $error("main flag not set after accepted result");
    AST_CFG_HOLD: assert property (cs_n_i [*2] |-> $stable({filter_code_o, main_range_o, aux_input_sel_o}))
        else $error("configuration changed while deselected");
endmodule

bind dsa_serial_port dsa_serial_chk u_dsa_serial_chk (.*);

// ===== dsa_host_model.sv
// Serial master model that clocks transfers with the clock resting high.
`timescale 1ns/1ps
module dsa_host_model #(
    parameter int HALF = 20
) (
    input  logic clock_i,
    input  logic dout_i,
    input  logic dout_oe_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    // Set to model a host that keeps the select pin low for good.
    logic keep_sel = 1'b0;

    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end

    // A half period of 20 system clocks keeps the serial clock at 2.5 MHz.
    task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] r, output logic [31:0] oe);
        r  = '0;
        oe = '0;
        @(posedge clock_i);
        cs_n_o <= 1'b0;
        repeat (HALF) @(posedge clock_i);
        for (int i = n - 1; i >= 0; i--) begin
            sclk_o <= 1'b0;
            din_o  <= w[i];
            repeat (HALF) @(posedge clock_i);
            r[i]   = dout_i;
            oe[i]  = dout_oe_i;
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge clock_i);
        end
        cs_n_o <= ~keep_sel;
        // A released data line must not look like a held bit.
        din_o  <= ~w[0];
        repeat (HALF) @(posedge clock_i);
    endtask
endmodule

// ===== testbench.sv
// Self-checking bench for the dual converter serial port.
`timescale 1ns/1ps
module testbench import dsa_pkg::*;;
    logic              clock_i, sclk, cs_n, din, dout, dout_oe, ready_n, mr, ar, mflag, aflag;
    logic              rstn_i = 1'b0, mv = 1'b0, av = 1'b0;
    logic              sel_hi, sel_lo, pair, chop, burn, wide, span, buf_n;
    logic [MAIN_W-1:0] md = '0;
    logic [AUX_W-1:0]  ad = '0;
    logic [2:0]        rng, asel;
    logic [REG_W-1:0]  filt;
    logic [31:0]       r, oe, v, fv;
    logic [23:0]       q[$];
    int                err_count = 0, cmp_count = 0, cyc = 0;

    dsa_serial_port u_dsa_serial_port (.clock_i(clock_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .ready_n_o(ready_n), .main_valid_i(mv),
        .main_data_i(md), .main_ready_o(mr), .aux_valid_i(av), .aux_data_i(ad), .aux_ready_o(ar),
        .main_range_o(rng), .main_buf_n_o(buf_n), .main_input_sel_hi_o(sel_hi), .main_input_sel_lo_o(sel_lo),
        .input_pairing_cfg_o(pair), .chop_en_o(chop), .burnout_en_o(burn), .main_wide_o(wide),
        .aux_span_select_o(span), .aux_input_sel_o(asel), .filter_code_o(filt),
        .main_result_flag_o(mflag), .aux_result_flag_o(aflag));
    dsa_host_model u_dsa_host_model (.clock_i(clock_i), .dout_i(dout), .dout_oe_i(dout_oe), .sclk_o(sclk),
        .cs_n_o(cs_n), .din_o(din));

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // ==========
    // Expectations and transfers.
    function automatic logic [7:0] cmd(input logic rd, input logic [3:0] a);
        return {1'b0, rd, 2'b00, a};
    endfunction
    function automatic logic [7:0] msk(input int a);
        return a == 1 ? 8'h07 : a == 2 ? 8'h7f : a == 3 ? 8'h0f : 8'hff;
    endfunction
    function automatic logic [7:0] rstv(input int a);
        return a == 1 ? MODE_RST : a == 2 ? MAIN_RST : a == 3 ? AUX_RST : FILT_RST;
    endfunction
    function automatic logic [7:0] pins(input int a);
        return a == 1 ? {5'h00, chop, burn, pair} : a == 2 ? {1'b0, wide, sel_hi, sel_lo, buf_n, rng}
             : a == 3 ? {4'h0, span, asel} : filt;
    endfunction

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wreg(input int a, input logic [7:0] d);
        u_dsa_host_model.xfer(16, {16'h0, cmd(1'b0, a[3:0]), d}, r, oe);
        chk("write enable", oe, 0);
    endtask
    // Data bits of a read carry random noise on the input line.
    task automatic rreg(input int n, input int a);
        logic [31:0] w;
        w = $urandom;
        w[n+7 -: 8] = cmd(1'b1, a[3:0]);
        u_dsa_host_model.xfer(n + 8, w, r, oe);
        chk("read enable", oe, (32'h1 << n) - 1);
        r = r & ((32'h1 << n) - 1);
    endtask
    task automatic pushm(input logic [23:0] d);
        @(posedge clock_i);
        mv <= 1'b1;
        md <= d;
        do @(posedge clock_i); while (mr !== 1'b1);
        mv <= 1'b0;
    endtask
    task automatic pusha(input logic [15:0] d);
        @(posedge clock_i);
        av <= 1'b1;
        ad <= d;
        do @(posedge clock_i); while (ar !== 1'b1);
        av <= 1'b0;
    endtask

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            end_sim();
        end
    end

    // ==========
    // Scenarios.
    initial begin
        void'($urandom(59));
        repeat (20) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        chk("idle pins", {mflag, aflag, ready_n, dout_oe}, 4'b0010);
        for (int a = 1; a < 5; a++) begin
            chk("reset pins", pins(a), rstv(a) & msk(a));
            rreg(8, a);
            chk("reset read", r & msk(a), rstv(a) & msk(a));
        end
        wreg(0, 8'hff);
        chk("status write", {mflag, aflag}, 0);
        for (int k = 0; k < 8; k++) begin
            int a;
            a = k % 4 + 1;
            v = $urandom;
            wreg(a, v[7:0]);
            chk("config pins", pins(a), v[7:0] & msk(a));
            rreg(8, a);
            chk("config read", r & msk(a), v[7:0] & msk(a));
        end
        fv = {24'h0, filt};
        wreg(2, MAIN_RST);
        v = $urandom;
        pushm(v[23:0]);
        repeat (4) @(posedge clock_i);
        chk("main pending", {mflag, aflag, ready_n}, 3'b100);
        rreg(8, 0);
        chk("status", r & 3, 1);
        rreg(24, 5);
        chk("main data", r, {8'h0, v[23:0]});
        chk("main read", {mflag, ready_n}, 2'b01);
        for (int k = 0; k < 4; k++) begin
            v = $urandom;
            q.push_back(v[23:0]);
        end
        for (int k = 0; k < 3; k++) begin
            pushm(q[k]);
        end
        fork
            pushm(q[3]);
        join_none
        repeat (20) @(posedge clock_i);
        chk("buffer full", mr, 0);
        while (q.size() > 0) begin
            rreg(24, 5);
            chk("buffer order", r, {8'h0, q.pop_front()});
        end
        wreg(2, MAIN_RST & 8'h3f);
        v = $urandom;
        pushm(v[23:0]);
        pusha(v[31:16]);
        repeat (4) @(posedge clock_i);
        rreg(8, 0);
        chk("status both", r & 3, 3);
        rreg(16, 5);
        chk("short main", r, {16'h0, v[23:8]});
        chk("aux unread", ready_n, 0);
        rreg(16, 6);
        chk("aux data", r, {16'h0, v[31:16]});
        chk("all read", {mflag, aflag, ready_n}, 3'b001);
        chk("filter kept", filt, fv);
        u_dsa_host_model.keep_sel = 1'b1;
        wreg(3, 8'h0a);
        rreg(8, 3);
        chk("tied select read", r, 8'h0a);
        chk("tied select pins", {cs_n, span, asel}, 5'h0a);
        end_sim();
    end
endmodule
